// >>> logic/instr_timing_map.vh
/*
 * instr_timing_map.vh
 * constants for the instruction length and cycle decoder: table codes,
 * memory space boundaries and timing. assumes plain verilog-2005 includes.
 */
`ifndef INSTR_TIMING_MAP_VH
`define INSTR_TIMING_MAP_VH

// length / cycle figures
`define LEN_ONE          2'd1
`define LEN_TWO          2'd2
`define LEN_THREE        2'd3
`define CYC_ONE          2'd1
`define CYC_TWO          2'd2
`define CYC_THREE        2'd3

// upper bound of the lower data half
`define LOWER_HALF_TOP   8'h7f

// operand addressing spaces reported per access
`define SPACE_NONE       2'd0
`define SPACE_LOW_RAM    2'd1
`define SPACE_SFR        2'd2
`define SPACE_HIGH_RAM   2'd3

// operation classes
`define CLS_NONE         4'h0
`define CLS_XOR          4'h1
`define CLS_OR           4'h2
`define CLS_ROTATE       4'h3
`define CLS_MOVE         4'h4
`define CLS_PTR_LOAD     4'h5
`define CLS_CODE_LOOKUP  4'h6
`define CLS_EXT_DATA     4'h7
`define CLS_STACK        4'h8
`define CLS_NIBBLE_XCH   4'h9

// addressing kind of the data operand
`define AM_NONE          2'd0
`define AM_DIRECT        2'd1
`define AM_INDIRECT      2'd2

`endif

// >>> logic/opcode_table.v
/*
 * opcode_table.v
 * pure combinational lookup: opcode byte to length, cycle count, class
 * and operand addressing kind. assumes the caller samples the outputs.
 */
`timescale 1ns/10ps
`default_nettype none
`include "instr_timing_map.vh"

module opcode_table (
    input  wire [7:0] opcode_i,   // first byte of the instruction
    output reg  [1:0] length_o,   // encoded bytes, 0 when unknown
    output reg  [1:0] cycles_o,   // core clock cycles, 0 when unknown
    output reg  [3:0] class_o,    // operation class
    output reg  [1:0] mode_o,     // data operand addressing kind
    output reg        known_o     // opcode is in this decoder's subset
);

    // table lookup; unknown opcodes fall out with zeros
    always @* begin
        length_o = 2'd0;
        cycles_o = 2'd0;
        class_o  = `CLS_NONE;
        mode_o   = `AM_NONE;
        known_o  = 1'b1;
        casez (opcode_i)
            8'h43: begin // or immediate into direct
                length_o = `LEN_THREE; cycles_o = `CYC_THREE;
                class_o = `CLS_OR; mode_o = `AM_DIRECT;
            end
            8'b0110_1???: begin // xor working register
                length_o = `LEN_ONE; cycles_o = `CYC_ONE; class_o = `CLS_XOR;
            end
            8'h65: begin // xor direct into acc
                length_o = `LEN_TWO; cycles_o = `CYC_TWO;
                class_o = `CLS_XOR; mode_o = `AM_DIRECT;
            end
            8'h66, 8'h67: begin // xor indirect
                length_o = `LEN_ONE; cycles_o = `CYC_TWO;
                class_o = `CLS_XOR; mode_o = `AM_INDIRECT;
            end
            8'h64: begin // xor immediate into acc
                length_o = `LEN_TWO; cycles_o = `CYC_TWO; class_o = `CLS_XOR;
            end
            8'h62: begin // xor acc into direct
                length_o = `LEN_TWO; cycles_o = `CYC_TWO;
                class_o = `CLS_XOR; mode_o = `AM_DIRECT;
            end
            8'h63: begin // xor immediate into direct
                length_o = `LEN_THREE; cycles_o = `CYC_THREE;
                class_o = `CLS_XOR; mode_o = `AM_DIRECT;
            end
            8'h33, 8'h13: begin // rotates through carry
                length_o = `LEN_ONE; cycles_o = `CYC_ONE; class_o = `CLS_ROTATE;
            end
            8'he5: begin // direct into acc
                length_o = `LEN_TWO; cycles_o = `CYC_TWO;
                class_o = `CLS_MOVE; mode_o = `AM_DIRECT;
            end
            8'he6, 8'he7: begin // indirect into acc
                length_o = `LEN_ONE; cycles_o = `CYC_TWO;
                class_o = `CLS_MOVE; mode_o = `AM_INDIRECT;
            end
            8'b1010_1???: begin // direct into working register
                length_o = `LEN_TWO; cycles_o = `CYC_TWO;
                class_o = `CLS_MOVE; mode_o = `AM_DIRECT;
            end
            8'b0111_1???: begin // immediate into working register
                length_o = `LEN_TWO; cycles_o = `CYC_TWO; class_o = `CLS_MOVE;
            end
            8'h85, 8'h75: begin // direct/immediate into direct
                length_o = `LEN_THREE; cycles_o = `CYC_THREE;
                class_o = `CLS_MOVE; mode_o = `AM_DIRECT;
            end
            8'h86, 8'h87, 8'ha6, 8'ha7: begin // indirect/direct pair
                length_o = `LEN_TWO; cycles_o = `CYC_TWO;
                class_o = `CLS_MOVE; mode_o = `AM_DIRECT;
            end
            8'h90: begin // sixteen-bit pointer load
                length_o = `LEN_THREE; cycles_o = `CYC_THREE;
                class_o = `CLS_PTR_LOAD;
            end
            8'h93, 8'h83: begin // code lookups
                length_o = `LEN_ONE; cycles_o = `CYC_THREE;
                class_o = `CLS_CODE_LOOKUP;
            end
            8'he2, 8'he3, 8'hf2, 8'hf3, 8'he0, 8'hf0: begin // external
                length_o = `LEN_ONE; cycles_o = `CYC_THREE;
                class_o = `CLS_EXT_DATA;
            end
            8'hc0, 8'hd0: begin // push / pop
                length_o = `LEN_TWO; cycles_o = `CYC_TWO;
                class_o = `CLS_STACK; mode_o = `AM_DIRECT;
            end
            8'hd6, 8'hd7: begin // low nibble exchange
                length_o = `LEN_ONE; cycles_o = `CYC_TWO;
                class_o = `CLS_NIBBLE_XCH; mode_o = `AM_INDIRECT;
            end
            default: begin // outside this decoder's subset
                known_o = 1'b0;
            end
        endcase
    end

endmodule // opcode_table
`default_nettype wire

// >>> logic/space_select.v
/*
 * space_select.v
 * picks the data space an operand address lands in from its addressing
 * kind. assumes address and kind are stable in the same cycle.
 */
`timescale 1ns/10ps
`default_nettype none
`include "instr_timing_map.vh"

module space_select (
    input  wire [7:0] addr_i,  // operand address
    input  wire [1:0] mode_i,  // addressing kind
    output reg  [1:0] space_o  // selected space
);

    // upper half splits by addressing kind, lower half is ram for direct and indirect
    always @* begin
        space_o = `SPACE_NONE;
        case (mode_i)
            `AM_DIRECT: begin
                if (addr_i > `LOWER_HALF_TOP) begin
                    space_o = `SPACE_SFR;
                end else begin
                    space_o = `SPACE_LOW_RAM;
                end
            end
            `AM_INDIRECT: begin
                if (addr_i > `LOWER_HALF_TOP) begin
                    space_o = `SPACE_HIGH_RAM;
                end else begin
                    space_o = `SPACE_LOW_RAM;
                end
            end
            default: begin
                space_o = `SPACE_NONE;
            end
        endcase
    end

endmodule // space_select
`default_nettype wire

// >>> logic/logic_move_instr_timing.v
/*
 * logic_move_instr_timing.v
 * fetch sequencer that times a subset of the core's instructions: it
 * requests each encoded byte, holds the instruction for its cycle count,
 * then fetches the next. assumes program memory answers in the cycle
 * after a request with byte_valid_i, on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "instr_timing_map.vh"

module logic_move_instr_timing #(
    parameter PC_W = 16                       // program counter width
) (
    input  wire            clock_i,           // core clock, 200 mhz
    input  wire            rst_i,             // synchronous reset, high
    input  wire [7:0]      byte_i,            // byte from program memory
    input  wire            byte_valid_i,      // byte_i holds requested byte
    input  wire [7:0]      indirect_addr_i,   // index register contents
    output reg             fetch_req_o,       // request one program byte
    output reg  [PC_W-1:0] fetch_addr_o,      // address of that byte
    output reg  [7:0]      opcode_o,          // opcode of current instr
    output reg  [7:0]      operand1_o,        // second encoded byte
    output reg  [7:0]      operand2_o,        // third encoded byte
    output reg  [1:0]      length_o,          // bytes of current instr
    output reg  [1:0]      cycles_o,          // cycles of current instr
    output reg  [3:0]      class_o,           // operation class
    output reg  [1:0]      space_o,           // operand data space
    output reg             execute_o,         // level: instr executing
    output reg             done_o,            // pulse: instr complete
    output reg             illegal_o          // pulse: opcode not decoded
);

    // sequencer states
    localparam ST_REQ    = 2'd0;  // issue a byte request
    localparam ST_WAIT   = 2'd1;  // wait for the byte
    localparam ST_EXEC   = 2'd2;  // count out the cycles
    localparam ST_FINISH = 2'd3;  // one-cycle completion

    reg [1:0]      state_q;       // sequencer state
    reg [1:0]      state_d;
    reg [PC_W-1:0] pc_q;          // next byte address
    reg [1:0]      got_q;         // bytes received so far
    reg [1:0]      cnt_q;         // cycles elapsed in execute
    reg [1:0]      mode_q;        // latched operand addressing kind
    reg [7:0]      addr_q;        // latched operand address

    wire [1:0] tbl_len;           // table outputs for the fetched opcode
    wire [1:0] tbl_cyc;
    wire [3:0] tbl_cls;
    wire [1:0] tbl_mode;
    wire       tbl_known;
    wire [1:0] sel_space;         // space for the latched operand

    // opcode lookup on the incoming first byte
    opcode_table u_table (
        .opcode_i (byte_i),
        .length_o (tbl_len),
        .cycles_o (tbl_cyc),
        .class_o  (tbl_cls),
        .mode_o   (tbl_mode),
        .known_o  (tbl_known)
    );

    // operand space from latched kind and address
    space_select u_space (
        .addr_i  (addr_q),
        .mode_i  (mode_q),
        .space_o (sel_space)
    );

    // two-bit increment helper, used by both counters
    function [1:0] inc2;
        input [1:0] v;
        begin
            inc2 = v + 2'd1;
        end
    endfunction

    // all bytes in hand once the count reaches the length
    wire last_byte = (got_q != 2'd0) && (inc2(got_q) == length_o);

    // next state
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_REQ: begin
                state_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (byte_valid_i) begin
                    if (got_q == 2'd0 && !tbl_known) begin
                        state_d = ST_REQ;          // skip unknown opcode
                    end else if ((got_q == 2'd0 && tbl_len == `LEN_ONE) || last_byte) begin
                        state_d = ST_EXEC;         // every byte fetched
                    end else begin
                        state_d = ST_REQ;
                    end
                end
            end
            ST_EXEC: begin
                // fetch time stays out of the hold: execute stands for
                // exactly the table count once the last byte is in
                if (inc2(cnt_q) >= cycles_o) begin
                    state_d = ST_FINISH;
                end
            end
            ST_FINISH: begin
                state_d = ST_REQ;                  // next fetch only now
            end
            default: begin
                state_d = ST_REQ;
            end
        endcase
    end

    // state, counters and latched decode
    always @(posedge clock_i) begin
        if (rst_i) begin
            state_q      <= ST_REQ;
            pc_q         <= {PC_W{1'b0}};
            got_q        <= 2'd0;
            cnt_q        <= 2'd0;
            mode_q       <= `AM_NONE;
            addr_q       <= 8'h00;
            fetch_req_o  <= 1'b0;
            fetch_addr_o <= {PC_W{1'b0}};
            opcode_o     <= 8'h00;
            operand1_o   <= 8'h00;
            operand2_o   <= 8'h00;
            length_o     <= 2'd0;
            cycles_o     <= 2'd0;
            class_o      <= `CLS_NONE;
            space_o      <= `SPACE_NONE;
            execute_o    <= 1'b0;
            done_o       <= 1'b0;
            illegal_o    <= 1'b0;
        end else begin
            state_q     <= state_d;
            fetch_req_o <= 1'b0;
            done_o      <= 1'b0;
            illegal_o   <= 1'b0;
            case (state_q)
                ST_REQ: begin
                    // present the request one cycle, pc moves with it
                    fetch_req_o  <= 1'b1;
                    fetch_addr_o <= pc_q;
                    pc_q         <= pc_q + {{(PC_W-1){1'b0}}, 1'b1};
                end
                ST_WAIT: begin
                    if (byte_valid_i) begin
                        got_q <= inc2(got_q);
                        if (got_q == 2'd0) begin
                            // opcode byte: latch the whole decode
                            opcode_o <= byte_i;
                            length_o <= tbl_len;
                            cycles_o <= tbl_cyc;
                            class_o  <= tbl_cls;
                            mode_q   <= tbl_mode;
                            addr_q   <= indirect_addr_i;
                            if (!tbl_known) begin
                                illegal_o <= 1'b1;
                                got_q     <= 2'd0;
                            end
                        end else if (got_q == 2'd1) begin
                            operand1_o <= byte_i;
                            // direct operand address is the second byte
                            if (mode_q == `AM_DIRECT) begin
                                addr_q <= byte_i;
                            end
                        end else begin
                            operand2_o <= byte_i;
                        end
                    end
                end
                ST_EXEC: begin
                    execute_o <= 1'b1;
                    space_o   <= sel_space;
                    cnt_q     <= inc2(cnt_q);
                end
                ST_FINISH: begin
                    execute_o <= 1'b0;
                    done_o    <= 1'b1;
                    got_q     <= 2'd0;
                    cnt_q     <= 2'd0;
                end
                default: begin
                    got_q <= 2'd0;
                end
            endcase
        end
    end

endmodule // logic_move_instr_timing
`default_nettype wire

// >>> verification/instr_timing_checker.sv
/*
 * instr_timing_checker.sv
 * concurrent checks on the fetch sequencer's ports: pulse widths, execute
 * hold lengths per cycle count, class timing and operand space.
 * assumes one core clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
`include "instr_timing_map.vh"

module instr_timing_checker #(
    parameter PC_W = 16                         // program counter width
) (
    input  wire logic            clock_i,       // core clock
    input  wire logic            rst_i,         // synchronous reset
    input  wire logic [7:0]      byte_i,        // program byte
    input  wire logic            byte_valid_i,  // program byte valid
    input  wire logic [7:0]      indirect_addr_i, // index register
    input  wire logic            fetch_req_o,   // byte request pulse
    input  wire logic [PC_W-1:0] fetch_addr_o,  // byte address
    input  wire logic [7:0]      opcode_o,      // opcode
    input  wire logic [7:0]      operand1_o,    // second byte
    input  wire logic [7:0]      operand2_o,    // third byte
    input  wire logic [1:0]      length_o,      // encoded length
    input  wire logic [1:0]      cycles_o,      // cycle count
    input  wire logic [3:0]      class_o,       // operation class
    input  wire logic [1:0]      space_o,       // operand space
    input  wire logic            execute_o,     // execute level
    input  wire logic            done_o,        // completion pulse
    input  wire logic            illegal_o      // unknown opcode pulse
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // execute holds of two and three cycles, built step by step
    sequence hold_two;
        execute_o ##1 !execute_o;
    endsequence
    sequence hold_three;
        execute_o ##1 execute_o ##1 !execute_o;
    endsequence

    req_pulse_a: assert property (fetch_req_o |=> !fetch_req_o)
        else $error("fetch request longer than one cycle");
    req_idle_a: assert property (execute_o |-> !fetch_req_o)
        else $error("fetch request while executing");
    exec_one_a: assert property ($rose(execute_o) && cycles_o == `CYC_ONE |=> !execute_o)
        else $error("one-cycle execute hold wrong");
    exec_two_a: assert property ($rose(execute_o) && cycles_o == `CYC_TWO |=> hold_two)
        else $error("two-cycle execute hold wrong");
    exec_three_a: assert property ($rose(execute_o) && cycles_o == `CYC_THREE |=> hold_three)
        else $error("three-cycle execute hold wrong");
    lookup_ext_a: assert property (execute_o && (class_o == `CLS_CODE_LOOKUP ||
        class_o == `CLS_EXT_DATA) |-> length_o == `LEN_ONE && cycles_o == `CYC_THREE)
        else $error("lookup or external timing wrong");
    ptr_load_a: assert property (execute_o && class_o == `CLS_PTR_LOAD |->
        length_o == `LEN_THREE && cycles_o == `CYC_THREE)
        else $error("pointer load timing wrong");
    stack_ops_a: assert property (execute_o && class_o == `CLS_STACK |->
        length_o == `LEN_TWO && cycles_o == `CYC_TWO)
        else $error("stack timing wrong");
    nibble_xch_a: assert property (execute_o && class_o == `CLS_NIBBLE_XCH |->
        length_o == `LEN_ONE && cycles_o == `CYC_TWO)
        else $error("nibble exchange timing wrong");
    sfr_space_a: assert property (execute_o && space_o == `SPACE_SFR |->
        operand1_o > `LOWER_HALF_TOP)
        else $error("special register space below upper half");
    done_pulse_a: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    done_next_a: assert property (done_o |-> ##[1:3] fetch_req_o)
        else $error("no fetch after completion");
endmodule // instr_timing_checker

bind logic_move_instr_timing instr_timing_checker #(.PC_W(PC_W)) chk_i (
    .clock_i, .rst_i, .byte_i, .byte_valid_i, .indirect_addr_i, .fetch_req_o, .fetch_addr_o,
    .opcode_o, .operand1_o, .operand2_o, .length_o, .cycles_o, .class_o, .space_o,
    .execute_o, .done_o, .illegal_o);
`default_nettype wire

// >>> verification/prog_mem_model.sv
/*
 * prog_mem_model.sv
 * program memory partner: answers each byte request after a chosen
 * number of wait cycles. assumes single-cycle requests on the core clock.
 */
`timescale 1ns/10ps
`default_nettype none

module prog_mem_model (
    input  wire logic        clock_i,      // core clock
    input  wire logic        rst_i,        // synchronous reset
    input  wire logic        fetch_req_i,  // byte request pulse
    input  wire logic [15:0] fetch_addr_i, // requested address
    input  wire logic [1:0]  wait_i,       // extra wait cycles
    output var  logic [7:0]  byte_o,       // returned byte
    output var  logic        byte_valid_o  // byte_o holds the byte
);
    logic [7:0] rom [0:255]; // image loaded by the bench
    logic [7:0] addr_q;      // address of the open request
    logic       pend_q;      // request waiting for its answer
    logic [1:0] cnt_q;       // wait cycles left
    logic       req_s;       // request seen at this edge

    initial begin
        byte_o = 8'h00;
        byte_valid_o = 1'b0;
        pend_q = 1'b0;
        cnt_q = 2'd0;
    end

    // sample at the edge, drive 1 ns later like any bench driver
    always @(posedge clock_i) begin
        req_s = fetch_req_i;
        if (req_s) addr_q = fetch_addr_i[7:0];
        #1;
        if (rst_i || byte_valid_o) begin // byte taken: release
            byte_valid_o = 1'b0;
            byte_o = ~byte_o;  // no stale byte left on the lines
            pend_q = 1'b0;
        end
        if (!rst_i && req_s) begin
            pend_q = 1'b1;
            cnt_q = wait_i;
        end else if (pend_q && cnt_q != 2'd0) begin // slow answer
            cnt_q = cnt_q - 2'd1;
        end
        if (pend_q && cnt_q == 2'd0) begin // answer now
            byte_valid_o = 1'b1;
            byte_o = rom[addr_q];
            pend_q = 1'b0;
        end
    end
endmodule // prog_mem_model
`default_nettype wire

// >>> verification/logic_move_instr_timing_tb.sv
/*
 * logic_move_instr_timing_tb.sv
 * self-checking bench: loads short programs, runs them and compares
 * fetch count, execute length and decode per instruction.
 * assumes the program memory model answers fetches.
 */
`timescale 1ns/10ps
`default_nettype none
`include "instr_timing_map.vh"

module logic_move_instr_timing_tb;
    logic        clock_i = 1'b0;          // core clock
    logic        rst_i = 1'b1;            // synchronous reset
    logic [7:0]  indirect_addr_i = 8'h20; // index register value
    logic [1:0]  wait_n = 2'd0;           // memory wait cycles
    wire  [7:0]  byte_i, opcode_o, operand1_o, operand2_o;
    wire  [15:0] fetch_addr_o;
    wire  [1:0]  length_o, cycles_o, space_o;
    wire  [3:0]  class_o;
    wire         byte_valid_i, fetch_req_o, execute_o, done_o, illegal_o;
    int          n_mismatch = 0;          // mismatches seen
    int          num_checks = 0;          // comparisons made
    int          pc, n_ins;               // program build cursor
    logic [7:0]  t_op [0:15];             // expected per instruction
    logic [7:0]  t_o1 [0:15];
    logic [7:0]  t_ind [0:15];
    int          t_len [0:15], t_cyc [0:15], t_sp [0:15], t_pc [0:15], t_cls [0:15];

    always #2.5 clock_i = ~clock_i;

    logic_move_instr_timing #(.PC_W(16)) uut (
        .clock_i, .rst_i, .byte_i, .byte_valid_i, .indirect_addr_i, .fetch_req_o,
        .fetch_addr_o, .opcode_o, .operand1_o, .operand2_o, .length_o, .cycles_o,
        .class_o, .space_o, .execute_o, .done_o, .illegal_o);

    prog_mem_model mem (.clock_i(clock_i), .rst_i(rst_i), .fetch_req_i(fetch_req_o),
        .fetch_addr_i(fetch_addr_o), .wait_i(wait_n), .byte_o(byte_i),
        .byte_valid_o(byte_valid_i));

    // one comparison, counted
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // empty image: 00 lies outside the decoded subset
    task clear_prog;
        for (int i = 0; i < 256; i++) mem.rom[i] = 8'h00;
        pc = 0;
        n_ins = 0;
    endtask

    // append one instruction; third byte is operand1 xor 5a
    task add(input logic [7:0] op, input int len, cyc, cls, input logic [7:0] o1 = 8'h30,
             input logic [7:0] ind = 8'h20, input int sp = -1);
        mem.rom[pc] = op;
        if (len > 1) mem.rom[pc+1] = o1;
        if (len > 2) mem.rom[pc+2] = o1 ^ 8'h5a;
        t_op[n_ins] = op;
        t_o1[n_ins] = o1;
        t_ind[n_ins] = ind;
        t_len[n_ins] = len;
        t_cyc[n_ins] = cyc;
        t_cls[n_ins] = cls;
        t_sp[n_ins] = sp;
        t_pc[n_ins] = pc;
        pc += len;
        n_ins++;
    endtask

    // reset, then follow each instruction to its done pulse
    task run_prog(input logic [1:0] w);
        int k, nf, ne;
        @(posedge clock_i);
        #1;
        rst_i = 1'b1;
        wait_n = w;
        indirect_addr_i = t_ind[0];
        repeat (2) @(posedge clock_i);
        #1 rst_i = 1'b0;
        for (int i = 0; i < n_ins; i++) begin
            nf = 0;
            ne = 0;
            k = 0;
            do begin
                @(posedge clock_i);
                #1;
                k++;
                if (fetch_req_o === 1'b1) begin
                    check("fetch_addr", fetch_addr_o, 16'(t_pc[i] + nf));
                    nf++;
                end
                if (execute_o === 1'b1) ne++;
            end while (done_o !== 1'b1 && k < 100);
            if (k >= 100) begin // hang: count it and stop
                n_mismatch++;
                $display("[ERR] done_o expected 1 seen none");
                give_verdict();
            end
            check("fetches", 16'(nf), 16'(t_len[i]));
            check("execute", 16'(ne), 16'(t_cyc[i]));
            check("opcode", opcode_o, t_op[i]);
            check("length", length_o, 16'(t_len[i]));
            check("cycles", cycles_o, 16'(t_cyc[i]));
            check("class", class_o, 16'(t_cls[i]));
            check("illegal", illegal_o, 1'b0);
            if (t_len[i] > 1) check("operand1", operand1_o, t_o1[i]);
            if (t_len[i] > 2) check("operand2", operand2_o, t_o1[i] ^ 8'h5a);
            if (t_sp[i] >= 0) check("space", space_o, 16'(t_sp[i]));
            if (i + 1 < n_ins) indirect_addr_i = t_ind[i+1];
        end
    endtask

    // logic ops and short moves back to back, prompt memory
    task scen_logic;
        clear_prog();
        add(8'h43, 3, 3, `CLS_OR);
        add(8'h6d, 1, 1, `CLS_XOR);
        add(8'h65, 2, 2, `CLS_XOR);
        add(8'h67, 1, 2, `CLS_XOR);
        add(8'h64, 2, 2, `CLS_XOR);
        add(8'h62, 2, 2, `CLS_XOR);
        add(8'h63, 3, 3, `CLS_XOR);
        add(8'h33, 1, 1, `CLS_ROTATE);
        add(8'h13, 1, 1, `CLS_ROTATE);
        add(8'he5, 2, 2, `CLS_MOVE);
        add(8'he6, 1, 2, `CLS_MOVE);
        add(8'haa, 2, 2, `CLS_MOVE);
        add(8'h7b, 2, 2, `CLS_MOVE);
        run_prog(2'd0);
    endtask

    // transfers with a slow memory: fetch waits stay out of the hold
    task scen_moves;
        clear_prog();
        add(8'h85, 3, 3, `CLS_MOVE);
        add(8'h87, 2, 2, `CLS_MOVE);
        add(8'h75, 3, 3, `CLS_MOVE);
        add(8'ha6, 2, 2, `CLS_MOVE);
        add(8'h90, 3, 3, `CLS_PTR_LOAD);
        add(8'h93, 1, 3, `CLS_CODE_LOOKUP);
        add(8'h83, 1, 3, `CLS_CODE_LOOKUP);
        add(8'he2, 1, 3, `CLS_EXT_DATA);
        add(8'hf3, 1, 3, `CLS_EXT_DATA);
        add(8'he0, 1, 3, `CLS_EXT_DATA);
        add(8'hf0, 1, 3, `CLS_EXT_DATA);
        add(8'hc0, 2, 2, `CLS_STACK);
        add(8'hd0, 2, 2, `CLS_STACK);
        add(8'hd7, 1, 2, `CLS_NIBBLE_XCH);
        run_prog(2'd2);
    endtask

    // operand space on both sides of the lower half boundary
    task scen_space;
        clear_prog();
        add(8'he5, 2, 2, `CLS_MOVE, 8'h80, 8'h20, `SPACE_SFR);
        add(8'he5, 2, 2, `CLS_MOVE, 8'h7f, 8'h20, `SPACE_LOW_RAM);
        add(8'he6, 1, 2, `CLS_MOVE, 8'h30, 8'h80, `SPACE_HIGH_RAM);
        add(8'he6, 1, 2, `CLS_MOVE, 8'h30, 8'h7f, `SPACE_LOW_RAM);
        run_prog(2'd1);
    endtask

    // opcode outside the subset must be flagged, never executed
    task scen_illegal;
        int k, seen;
        clear_prog();
        seen = 0;
        @(posedge clock_i);
        #1 rst_i = 1'b1;
        repeat (2) @(posedge clock_i);
        #1 rst_i = 1'b0;
        for (k = 0; k < 20 && seen == 0; k++) begin
            @(posedge clock_i);
            #1;
            if (illegal_o === 1'b1) seen = 1;
            if (execute_o === 1'b1) seen = 2;
        end
        check("illegal flag", 16'(seen), 16'd1);
    endtask

    initial begin
        repeat (2) @(posedge clock_i);
        scen_logic();
        scen_moves();
        scen_space();
        scen_illegal();
        give_verdict();
    end
endmodule // logic_move_instr_timing_tb
`default_nettype wire
